//--- core/fmra_pkg.sv
package fmra_pkg;
  localparam int          ADDR_W        = 20;
  localparam int          DATA_W        = 16;
  localparam int          CLK_NS        = 10;
  localparam int          CLK_MHZ       = 100;
  // Boot area, start vectors and user block size
  localparam logic [19:0] BOOT_BASE     = 20'hDE000;
  localparam logic [19:0] BOOT_SIZE     = 20'h02000;
  localparam logic [19:0] USER_START    = 20'hE0000;
  localparam logic [19:0] USER_BLK_SIZE = 20'h08000;
  // Command codes, low byte
  localparam logic [7:0]  CMD_READ      = 8'hFF;
  localparam logic [7:0]  CMD_RSTAT     = 8'h70;
  localparam logic [7:0]  CMD_CSTAT     = 8'h50;
  localparam logic [7:0]  CMD_PROG      = 8'h40;
  localparam logic [7:0]  CMD_ERASE     = 8'h20;
  localparam logic [7:0]  CMD_BCONF     = 8'hD0;
  // Status byte fields
  localparam int          ST_READY      = 7;
  localparam int          ST_ERASE_ERR  = 5;
  localparam int          ST_PROG_ERR   = 4;
  localparam logic [7:0]  STATUS_RST    = 8'h80;
  // Timing
  localparam int          PROG_TIME_NS  = 20000;
  localparam int          ERASE_TIME_US = 5000;
  localparam int          PROG_CYC      = (PROG_TIME_NS + CLK_NS - 1)
                                          / CLK_NS;
  localparam int          ERASE_CYC     = ERASE_TIME_US * CLK_MHZ;
  localparam logic [1:0]  STRAP_SETTLE  = 2'h3;

  typedef enum logic [3:0] {
    FMRA_MODE_NORMAL = 4'b0001,
    FMRA_MODE_PAR    = 4'b0010,
    FMRA_MODE_SER    = 4'b0100,
    FMRA_MODE_CPU    = 4'b1000
  } fmra_mode_e;

  typedef enum logic [3:0] {
    FMRA_CS_READ  = 4'b0001,
    FMRA_CS_STAT  = 4'b0010,
    FMRA_CS_PROG  = 4'b0100,
    FMRA_CS_ERASE = 4'b1000
  } fmra_cmd_e;
endpackage

//--- core/fmra_ctrl.sv
`timescale 1ns/1ns
module fmra_ctrl #(
  parameter int ERASE_CYCLES = fmra_pkg::ERASE_CYC,
  parameter int PROG_CYCLES  = fmra_pkg::PROG_CYC
) (
  input  wire  logic                        clk,
  input  wire  logic                        rstn,
  input  wire  logic                        processor_mode_strap,
  input  wire  logic                        boot_select_strap,
  input  wire  logic                        port_boot_strap,
  input  wire  logic                        rewrite_voltage_pin,
  input  wire  logic                        par_mode_pin,
  input  wire  logic                        ser_mode_pin,
  input  wire  logic                        readout_lock,
  input  wire  logic                        rewrite_sel_wr,
  input  wire  logic                        rewrite_sel_data,
  input  wire  logic                        flash_reset_bit,
  input  wire  logic                        cmd_wr,
  input  wire  logic [fmra_pkg::ADDR_W-1:0] cmd_addr,
  input  wire  logic [fmra_pkg::DATA_W-1:0] cmd_data,
  output logic                              start_valid,
  output logic                              start_is_boot,
  output logic [fmra_pkg::ADDR_W-1:0]       start_addr,
  output logic [3:0]                        mode,
  output logic                              rewrite_select,
  output logic                              rewrite_entered,
  output logic                              cpu_array_block,
  output logic                              readout_protect,
  output logic                              flash_ready_flag,
  output logic                              status_read_mode,
  output logic [7:0]                        status_byte,
  output logic                              op_start,
  output logic                              op_prog,
  output logic                              op_erase_blk,
  output logic                              op_erase_all,
  output logic [fmra_pkg::ADDR_W-1:0]       op_addr,
  output logic [fmra_pkg::DATA_W-1:0]       op_data,
  output logic                              cmd_refused
);
  import fmra_pkg::*;

  localparam int CNT_W = $clog2(ERASE_CYCLES + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;

  assign pin_raw = {processor_mode_strap, boot_select_strap,
                    port_boot_strap, rewrite_voltage_pin,
                    par_mode_pin, ser_mode_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  logic proc_s;
  logic bsel_s;
  logic port_s;
  logic volt_s;
  logic par_s;
  logic ser_s;

  assign {proc_s, bsel_s, port_s, volt_s, par_s, ser_s} = pin_s2;

  // ----------------------------------------------------------------
  // Strap capture at reset release
  // ----------------------------------------------------------------
  logic [1:0]        settle;
  logic [1:0]        next_settle;
  logic              next_start_valid;
  logic              next_start_is_boot;
  logic [ADDR_W-1:0] next_start_addr;

  always_comb begin
    next_settle        = settle;
    next_start_valid   = start_valid;
    next_start_is_boot = start_is_boot;
    next_start_addr    = start_addr;
    if (!start_valid) begin
      if (settle == STRAP_SETTLE) begin
        next_start_valid = 1'b1;
        if (!proc_s) begin
          next_start_is_boot = 1'b0;
          next_start_addr    = USER_START;
        end else if (!bsel_s && port_s) begin
          next_start_is_boot = 1'b1;
          next_start_addr    = BOOT_BASE;
        end else begin
          next_start_is_boot = 1'b0;
          next_start_addr    = USER_START;
        end
      end else begin
        next_settle = settle + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settle        <= 2'h0;
      start_valid   <= 1'b0;
      start_is_boot <= 1'b0;
      start_addr    <= '0;
    end else begin
      settle        <= next_settle;
      start_valid   <= next_start_valid;
      start_is_boot <= next_start_is_boot;
      start_addr    <= next_start_addr;
    end
  end

  // ----------------------------------------------------------------
  // Rewrite select bit and mode
  // ----------------------------------------------------------------
  logic       sel_armed;
  logic       next_sel_armed;
  logic       next_rewrite_select;
  fmra_mode_e next_mode;

  always_comb begin
    next_sel_armed      = sel_armed;
    next_rewrite_select = rewrite_select;
    if (rewrite_sel_wr) begin
      if (!rewrite_sel_data) begin
        next_rewrite_select = 1'b0;
        next_sel_armed      = 1'b1;
      end else begin
        // Set only when the previous select write was a zero
        if (sel_armed) begin
          next_rewrite_select = 1'b1;
        end
        next_sel_armed = 1'b0;
      end
    end
    // Priority: parallel, serial, CPU rewrite
    if (par_s) begin
      next_mode = FMRA_MODE_PAR;
    end else if (ser_s) begin
      next_mode = FMRA_MODE_SER;
    end else if (rewrite_select && volt_s) begin
      next_mode = FMRA_MODE_CPU;
    end else begin
      next_mode = FMRA_MODE_NORMAL;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_armed       <= 1'b0;
      rewrite_select  <= 1'b0;
      mode            <= FMRA_MODE_NORMAL;
      rewrite_entered <= 1'b0;
      cpu_array_block <= 1'b0;
      readout_protect <= 1'b0;
    end else begin
      sel_armed       <= next_sel_armed;
      rewrite_select  <= next_rewrite_select;
      mode            <= next_mode;
      rewrite_entered <= (next_mode == FMRA_MODE_CPU);
      cpu_array_block <= (next_mode == FMRA_MODE_CPU);
      readout_protect <= readout_lock &&
                         (next_mode == FMRA_MODE_PAR ||
                          next_mode == FMRA_MODE_SER);
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer and operation timer
  // ----------------------------------------------------------------
  fmra_cmd_e         cstate;
  fmra_cmd_e         next_cstate;
  logic [CNT_W-1:0]  busy_cnt;
  logic [CNT_W-1:0]  next_busy_cnt;
  logic [7:0]        next_status;
  logic              next_op_start;
  logic              next_op_prog;
  logic              next_op_erase_blk;
  logic              next_op_erase_all;
  logic [ADDR_W-1:0] next_op_addr;
  logic [DATA_W-1:0] next_op_data;
  logic              next_refused;
  logic              busy;
  logic              cmd_ok;
  logic              in_boot;
  logic              boot_ok;
  logic [7:0]        code;

  assign busy    = (busy_cnt != '0);
  assign code    = cmd_data[7:0];
  assign cmd_ok  = cmd_wr && !cmd_addr[0] && !busy &&
                   (mode != FMRA_MODE_NORMAL);
  assign in_boot = (cmd_addr >= BOOT_BASE) &&
                   (cmd_addr < BOOT_BASE + BOOT_SIZE);
  assign boot_ok = (mode == FMRA_MODE_PAR);

  always_comb begin
    next_cstate       = cstate;
    next_busy_cnt     = busy ? busy_cnt - 1'b1 : busy_cnt;
    next_status       = status_byte;
    next_op_start     = 1'b0;
    next_op_prog      = op_prog;
    next_op_erase_blk = op_erase_blk;
    next_op_erase_all = op_erase_all;
    next_op_addr      = op_addr;
    next_op_data      = op_data;
    next_refused      = 1'b0;
    next_status[ST_READY] = !busy || (busy_cnt == 1);
    if (flash_reset_bit && rewrite_select) begin
      // Control circuit reset aborts any operation
      next_cstate           = FMRA_CS_READ;
      next_busy_cnt         = '0;
      next_status[ST_READY] = 1'b1;
    end else if (cmd_ok) begin
      unique case (cstate)
        FMRA_CS_READ, FMRA_CS_STAT: begin
          if (code == CMD_READ) begin
            next_cstate = FMRA_CS_READ;
          end else if (code == CMD_RSTAT) begin
            next_cstate = FMRA_CS_STAT;
          end else if (code == CMD_CSTAT) begin
            next_status[ST_ERASE_ERR] = 1'b0;
            next_status[ST_PROG_ERR]  = 1'b0;
          end else if (code == CMD_PROG) begin
            next_cstate = FMRA_CS_PROG;
          end else if (code == CMD_ERASE) begin
            next_cstate = FMRA_CS_ERASE;
          end
        end
        FMRA_CS_PROG: begin
          next_cstate = FMRA_CS_STAT;
          if (in_boot && !boot_ok) begin
            next_refused             = 1'b1;
            next_status[ST_PROG_ERR] = 1'b1;
          end else begin
            // One word per program command
            next_op_start         = 1'b1;
            next_op_prog          = 1'b1;
            next_op_erase_blk     = 1'b0;
            next_op_erase_all     = 1'b0;
            next_op_addr          = cmd_addr;
            next_op_data          = cmd_data;
            next_busy_cnt         = CNT_W'(PROG_CYCLES);
            next_status[ST_READY] = 1'b0;
          end
        end
        FMRA_CS_ERASE: begin
          next_cstate = FMRA_CS_STAT;
          if (code == CMD_ERASE) begin
            // Whole user area at once
            next_op_start         = 1'b1;
            next_op_prog          = 1'b0;
            next_op_erase_blk     = 1'b0;
            next_op_erase_all     = 1'b1;
            next_op_addr          = '0;
            next_op_data          = '0;
            next_busy_cnt         = CNT_W'(ERASE_CYCLES);
            next_status[ST_READY] = 1'b0;
          end else if (code == CMD_BCONF) begin
            if (in_boot && !boot_ok) begin
              next_refused              = 1'b1;
              next_status[ST_ERASE_ERR] = 1'b1;
            end else begin
              next_op_start     = 1'b1;
              next_op_prog      = 1'b0;
              next_op_erase_blk = 1'b1;
              next_op_erase_all = 1'b0;
              // Boot area is erased as one undivided block
              next_op_addr = in_boot ? BOOT_BASE :
                             (cmd_addr & ~(USER_BLK_SIZE - 20'h00001));
              next_op_data          = '0;
              next_busy_cnt         = CNT_W'(ERASE_CYCLES);
              next_status[ST_READY] = 1'b0;
            end
          end else begin
            next_status[ST_ERASE_ERR] = 1'b1;
          end
        end
        default: begin
          next_cstate = FMRA_CS_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cstate           <= FMRA_CS_READ;
      busy_cnt         <= '0;
      status_byte      <= STATUS_RST;
      op_start         <= 1'b0;
      op_prog          <= 1'b0;
      op_erase_blk     <= 1'b0;
      op_erase_all     <= 1'b0;
      op_addr          <= '0;
      op_data          <= '0;
      cmd_refused      <= 1'b0;
      flash_ready_flag <= 1'b1;
      status_read_mode <= 1'b0;
    end else begin
      cstate           <= next_cstate;
      busy_cnt         <= next_busy_cnt;
      status_byte      <= next_status;
      op_start         <= next_op_start;
      op_prog          <= next_op_prog;
      op_erase_blk     <= next_op_erase_blk;
      op_erase_all     <= next_op_erase_all;
      op_addr          <= next_op_addr;
      op_data          <= next_op_data;
      cmd_refused      <= next_refused;
      flash_ready_flag <= next_status[ST_READY];
      status_read_mode <= (next_cstate == FMRA_CS_STAT);
    end
  end

endmodule

//--- verification/fmra_cpu_model.sv
`timescale 1ns/1ns
module fmra_cpu_model (
  input  wire logic                  clk,
  input  wire logic                  cpu_array_block,
  output logic                       cmd_wr,
  output logic [fmra_pkg::ADDR_W-1:0] cmd_addr,
  output logic [fmra_pkg::DATA_W-1:0] cmd_data,
  output logic                       rewrite_sel_wr,
  output logic                       rewrite_sel_data,
  output logic                       flash_reset_bit
);
  import fmra_pkg::*;
  logic fetch_en;
  // Routine runs from RAM, no array fetch
  assign fetch_en = !cpu_array_block;
  initial begin
    {cmd_wr, rewrite_sel_wr, rewrite_sel_data, flash_reset_bit} = '0;
    cmd_addr = '0;
    cmd_data = '0;
  end
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    cmd_wr   <= 1'b1;
    cmd_addr <= a;
    cmd_data <= d;
  endtask
  task frst(input logic d);
    @(posedge clk);
    flash_reset_bit <= d;
  endtask
  task sel(input logic d);
    @(posedge clk);
    rewrite_sel_wr   <= 1'b1;
    rewrite_sel_data <= d;
  endtask
  // Released lines never keep the last value
  task idle(input int n);
    repeat (n) begin
      @(posedge clk);
      cmd_wr           <= 1'b0;
      rewrite_sel_wr   <= 1'b0;
      cmd_addr         <= ~cmd_addr;
      cmd_data         <= ~cmd_data;
      rewrite_sel_data <= ~rewrite_sel_data;
    end
  endtask
endmodule

//--- verification/fmra_ctrl_asserts.sv
`timescale 1ns/1ns
module fmra_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_wr,
  input wire logic [fmra_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [fmra_pkg::DATA_W-1:0] cmd_data,
  input wire logic start_valid,
  input wire logic start_is_boot,
  input wire logic [fmra_pkg::ADDR_W-1:0] start_addr,
  input wire logic [3:0] mode,
  input wire logic rewrite_select,
  input wire logic cpu_array_block,
  input wire logic readout_protect,
  input wire logic flash_ready_flag,
  input wire logic op_start,
  input wire logic op_prog,
  input wire logic [fmra_pkg::ADDR_W-1:0] op_addr,
  input wire logic [fmra_pkg::DATA_W-1:0] op_data,
  input wire logic cmd_refused
);
  import fmra_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_prog_first;
    cmd_wr && !cmd_addr[0] && cmd_data[7:0] == CMD_PROG && mode != 4'h1
      && flash_ready_flag;
  endsequence
  sequence s_prog_word;
    cmd_wr && !cmd_addr[0] && cmd_addr >= USER_START;
  endsequence
  a_mode_onehot: assert property ($onehot(mode))
    else $error("mode not one-hot");
  a_boot_par_only: assert property (op_start && op_addr >= BOOT_BASE
    && op_addr < USER_START |-> mode == 4'h2)
    else $error("boot area operation outside parallel mode");
  a_refuse_boot: assert property (cmd_refused |-> mode != 4'h2
    && !op_start)
    else $error("refusal in parallel mode");
  a_prog_launch: assert property (s_prog_first ##1 s_prog_word |=>
    op_start && op_prog && op_addr == $past(cmd_addr)
    && op_data == $past(cmd_data))
    else $error("program not launched");
  a_ready_op: assert property (op_start |-> !flash_ready_flag
    ##[1:40] flash_ready_flag)
    else $error("ready flag wrong around operation");
  a_cpu_blocks: assert property (mode == 4'h8 |-> cpu_array_block
    && $past(rewrite_select))
    else $error("rewrite mode without select or block");
  a_odd_ignored: assert property (cmd_wr && cmd_addr[0] |=> !op_start)
    else $error("odd address command acted on");
  a_protect_mode: assert property (readout_protect |->
    mode inside {4'h2, 4'h4} || $past(mode) inside {4'h2, 4'h4})
    else $error("protection outside programmer modes");
  a_start_held: assert property (start_valid |=> start_valid
    && $stable(start_addr) && $stable(start_is_boot))
    else $error("start mode changed");
  a_start_vec: assert property (start_valid |->
    start_addr == (start_is_boot ? BOOT_BASE : USER_START))
    else $error("start address wrong");
endmodule
bind fmra_ctrl fmra_asserts u_chk (
  .clk, .rstn, .cmd_wr, .cmd_addr, .cmd_data, .start_valid,
  .start_is_boot, .start_addr, .mode, .rewrite_select, .cpu_array_block,
  .readout_protect, .flash_ready_flag, .op_start, .op_prog, .op_addr,
  .op_data, .cmd_refused);

//--- verification/tb_flash_mode_and_rewrite_access.sv
`timescale 1ns/1ns
module tb_flash_mode_and_rewrite_access;
  import fmra_pkg::*;
  logic clk, rstn, processor_mode_strap, boot_select_strap;
  logic port_boot_strap, rewrite_voltage_pin, par_mode_pin, ser_mode_pin;
  logic readout_lock, rewrite_sel_wr, rewrite_sel_data, flash_reset_bit;
  logic cmd_wr, start_valid, start_is_boot, rewrite_select;
  logic cpu_array_block, readout_protect, flash_ready_flag, op_start;
  logic op_prog, op_erase_blk, op_erase_all, cmd_refused;
  logic rewrite_entered, status_read_mode;
  logic [7:0]  status_byte;
  logic [3:0]  mode;
  logic [19:0] cmd_addr, start_addr, op_addr;
  logic [15:0] cmd_data, op_data;
  int miscompares, cmp_count;
  // Straps: cpu, boot select, port, boot start expected
  logic [3:0] rows [5] = '{4'h0, 4'h6, 4'hE, 4'h8, 4'hB};
  fmra_ctrl #(.ERASE_CYCLES(20), .PROG_CYCLES(5)) u_dut (
    .clk, .rstn, .processor_mode_strap, .boot_select_strap,
    .port_boot_strap, .rewrite_voltage_pin, .par_mode_pin, .ser_mode_pin,
    .readout_lock, .rewrite_sel_wr, .rewrite_sel_data, .flash_reset_bit,
    .cmd_wr, .cmd_addr, .cmd_data, .start_valid, .start_is_boot,
    .start_addr, .mode, .rewrite_select, .rewrite_entered,
    .cpu_array_block, .readout_protect, .flash_ready_flag,
    .status_read_mode, .status_byte, .op_start, .op_prog,
    .op_erase_blk, .op_erase_all, .op_addr, .op_data, .cmd_refused);
  fmra_cpu_model cpu (.clk, .cpu_array_block, .cmd_wr, .cmd_addr,
    .cmd_data, .rewrite_sel_wr, .rewrite_sel_data, .flash_reset_bit);
  task chk(input string n, input logic [19:0] e, input logic [19:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task rst(input logic [3:0] r);
    @(posedge clk);
    rstn                 <= 1'b0;
    processor_mode_strap <= r[3];
    boot_select_strap    <= r[2];
    port_boot_strap      <= r[1];
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task op(input logic [15:0] c, input logic [19:0] a, input logic [15:0] d);
    cpu.wr(a, c);
    cpu.wr(a, d);
    cpu.idle(1);
    #1;
  endtask
  task wait_rdy;
    int n;
    n = 0;
    while (flash_ready_flag !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ready", 20'h1, flash_ready_flag);
  endtask
  // Programmer pins take a few edges through the synchroniser
  task pins(input logic p, input logic s);
    @(posedge clk);
    par_mode_pin <= p;
    ser_mode_pin <= s;
    repeat (5) @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results;
  end
  initial begin
    {rstn, processor_mode_strap, boot_select_strap, port_boot_strap} = '0;
    {rewrite_voltage_pin, par_mode_pin, ser_mode_pin, readout_lock} = '0;
    miscompares = 0;
    cmp_count = 0;
    foreach (rows[i]) begin
      rst(rows[i]);
      chk("valid", 20'h1, start_valid);
      chk("boot", {19'h0, rows[i][0]}, start_is_boot);
      chk("vec", rows[i][0] ? BOOT_BASE : USER_START, start_addr);
    end
    // -------------------------------------------------------------
    // Rewrite entry, operations, refusals
    // -------------------------------------------------------------
    @(posedge clk);
    processor_mode_strap <= 1'b0;
    rewrite_voltage_pin  <= 1'b1;
    readout_lock         <= 1'b1;
    cpu.sel(1'b1);
    cpu.idle(5);
    chk("held", BOOT_BASE, start_addr);
    chk("unarmed", 20'h0, rewrite_select);
    op(16'h0040, 20'hE0010, 16'h1234);
    chk("normal", 20'h0, op_start);
    chk("noent", 20'h0, rewrite_entered);
    chk("prot", 20'h0, readout_protect);
    cpu.sel(1'b0);
    cpu.sel(1'b1);
    cpu.idle(1);
    repeat (2) @(posedge clk);
    #1;
    chk("mode", 20'h8, mode);
    chk("block", 20'h1, cpu_array_block);
    chk("entered", 20'h1, rewrite_entered);
    op(16'hAB40, 20'hE0010, 16'h1234);
    chk("start", 20'h1, op_start);
    chk("prog", 20'h1, op_prog);
    chk("addr", 20'hE0010, op_addr);
    chk("data", 20'h1234, op_data);
    chk("busy", 20'h0, flash_ready_flag);
    chk("stat", 20'h00, status_byte);
    chk("srm", 20'h1, status_read_mode);
    wait_rdy;
    op(16'h0020, 20'hE8000, 16'h77D0);
    chk("blk", 20'h1, op_erase_blk);
    chk("baddr", 20'hE8000, op_addr);
    wait_rdy;
    op(16'h0020, 20'hE0000, 16'h0020);
    chk("all", 20'h1, op_erase_all);
    wait_rdy;
    op(16'h0040, 20'hE0011, 16'h0040);
    chk("odd", 20'h0, op_start);
    op(16'h0040, 20'hDE010, 16'h0001);
    chk("refp", 20'h1, cmd_refused);
    chk("nop", 20'h0, op_start);
    chk("perr", 20'h90, status_byte);
    op(16'h0020, BOOT_BASE, 16'h00D0);
    chk("refe", 20'h1, cmd_refused);
    chk("eerr", 20'hB0, status_byte);
    op(16'h0050, 20'hE0000, 16'h0050);
    chk("clr", 20'h80, status_byte);
    chk("srm", 20'h1, status_read_mode);
    op(16'h0070, 20'hE0000, 16'h00FF);
    chk("rdarr", 20'h0, status_read_mode);
    pins(1'b1, 1'b0);
    chk("par", 20'h2, mode);
    chk("prot", 20'h1, readout_protect);
    op(16'h0040, 20'hDFFFE, 16'hBEEF);
    chk("bootp", 20'h1, op_start);
    wait_rdy;
    pins(1'b0, 1'b1);
    chk("ser", 20'h4, mode);
    chk("prot", 20'h1, readout_protect);
    op(16'h0040, 20'hDE000, 16'h0001);
    chk("refs", 20'h1, cmd_refused);
    @(posedge clk);
    readout_lock <= 1'b0;
    @(posedge clk);
    #1;
    chk("unlock", 20'h0, readout_protect);
    @(posedge clk);
    readout_lock <= 1'b1;
    pins(1'b0, 1'b0);
    chk("back", 20'h8, mode);
    chk("prot", 20'h0, readout_protect);
    // -------------------------------------------------------------
    // Control circuit reset, rewrite exit
    // -------------------------------------------------------------
    op(16'h0020, 20'hE0000, 16'h0020);
    chk("ebusy", 20'h0, flash_ready_flag);
    cpu.frst(1'b1);
    cpu.frst(1'b0);
    #1;
    chk("abort", 20'h1, flash_ready_flag);
    chk("abrd", 20'h0, status_read_mode);
    @(posedge clk);
    rewrite_voltage_pin <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("exit", 20'h1, mode);
    chk("unblk", 20'h0, cpu_array_block);
    chk("noent", 20'h0, rewrite_entered);
    results;
  end
endmodule
